// *** hw/stc_pkg.sv ***
// Package: register map, field positions and constants of the timer control block
package stc_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFF_CONTROL    = 8'h10;
    localparam logic [7:0] OFF_COUNT_LOW  = 8'h0E;
    localparam logic [7:0] OFF_COUNT_HIGH = 8'h0F;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h21;
    localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h22;
    localparam logic [7:0] OFF_PORT_DIR   = 8'h23;
    localparam logic [7:0] OFF_PORT_READ  = 8'h24;
    // ************************************************************
    // Control fields and reset values
    // ************************************************************
    localparam int         BIT_RUN        = 0;
    localparam int         BIT_SRC        = 1;
    localparam int         BIT_SYNC_N     = 2;
    localparam int         BIT_OSC_EN     = 3;
    localparam int         BIT_PS_LO      = 4;
    localparam int         BIT_PS_HI      = 5;
    localparam logic [7:0] CONTROL_MASK   = 8'h3F;
    localparam logic [7:0] CONTROL_RESET  = 8'h00;
    localparam logic [7:0] PORT_DIR_RESET = 8'hFF;
    localparam int         IRQ_OVF        = 0;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam logic [1:0] INT_DIV_LAST   = 2'h3;
    localparam logic [2:0] PS_DIV8        = 3'h7;
    localparam logic [2:0] PS_DIV4        = 3'h3;
    localparam logic [2:0] PS_DIV2        = 3'h1;
    localparam logic [2:0] PS_DIV1        = 3'h0;
endpackage

// *** hw/stc_prescaler.sv ***
// Module: timer input prescaler producing one-cycle count enables
`timescale 1ns/1ps
module stc_prescaler
    import stc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       tickIn,
    input  wire logic [1:0] sel,
    input  wire logic       clearDiv,
    output      logic       tickOut
);
    logic [2:0] cnt_r;
    logic [2:0] limit;

    always_comb
    begin
        unique case (sel)
            2'b11: limit = PS_DIV8;
            2'b10: limit = PS_DIV4;
            2'b01: limit = PS_DIV2;
            2'b00: limit = PS_DIV1;
        endcase
    end

    // Divide incoming ticks
    always_ff @(posedge clock)
    begin
        if (!rst_n || clearDiv)
            cnt_r <= 3'h0;
        else if (tickIn)
            cnt_r <= (cnt_r >= limit) ? 3'h0 : 3'(cnt_r + 3'h1);
    end

    assign tickOut = tickIn && (cnt_r >= limit);
endmodule

// *** hw/stc_timer.sv ***
// Module: sixteen-bit timer/counter with control register and overflow interrupt
`timescale 1ns/1ps
module stc_timer
    import stc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output      logic [7:0] regRdata,
    input  wire logic       extClockPin,
    input  wire logic       oscInPin,
    input  wire logic       portC0Out,
    input  wire logic       portC1Out,
    output      logic       oscEnableOut,
    output      logic       pinC0Oe,
    output      logic       pinC1Oe,
    output      logic       pinC0Data,
    output      logic       pinC1Data,
    output      logic       irq
);
    // ************************************************************
    // State
    // ************************************************************
    logic [7:0]  control_r;
    logic [7:0]  portDir_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [1:0]  intDiv_r;
    logic        extSync1_r;
    logic        extSync2_r;
    logic        extPrev_r;
    logic        rawPrev_r;
    logic        irqStatus_r;
    logic        irqEnable_r;
    logic        intTick;
    logic        extEdgeSync;
    logic        extEdgeRaw;
    logic        srcTick;
    logic        countTick;
    logic        wrap;
    logic        wrCtl;

    assign wrCtl = regWrite && (regAddr == OFF_CONTROL);

    // ************************************************************
    // Control and port direction registers
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            control_r <= CONTROL_RESET;
        else if (wrCtl)
            control_r <= regWdata & CONTROL_MASK;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            portDir_r <= PORT_DIR_RESET;
        else if (regWrite && regAddr == OFF_PORT_DIR)
            portDir_r <= regWdata;
    end

    // ************************************************************
    // Clock sources
    // ************************************************************
    // Quarter-rate internal tick
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            intDiv_r <= 2'h0;
        else
            intDiv_r <= 2'(intDiv_r + 2'h1);
    end
    assign intTick = (intDiv_r == INT_DIV_LAST);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            extSync1_r <= 1'b0;
            extSync2_r <= 1'b0;
            extPrev_r  <= 1'b0;
            rawPrev_r  <= 1'b0;
        end
        else
        begin
            extSync1_r <= extClockPin;
            extSync2_r <= extSync1_r;
            extPrev_r  <= extSync2_r;
            rawPrev_r  <= extClockPin;
        end
    end
    assign extEdgeSync = extSync2_r && !extPrev_r;
    assign extEdgeRaw  = extClockPin && !rawPrev_r;

    always_comb
    begin
        if (!control_r[BIT_SRC])
            srcTick = intTick;
        else if (!control_r[BIT_SYNC_N])
            srcTick = extEdgeSync;
        else
            srcTick = extEdgeRaw;
    end

    stc_prescaler u_prescaler
    (
        .clock    (clock),
        .rst_n    (rst_n),
        .tickIn   (srcTick),
        .sel      ({control_r[BIT_PS_HI], control_r[BIT_PS_LO]}),
        .clearDiv (wrCtl),
        .tickOut  (countTick)
    );

    // ************************************************************
    // Counter
    // ************************************************************
    assign wrap = control_r[BIT_RUN] && countTick && (count_r == 16'hFFFF);

    always_comb
    begin
        count_nxt = count_r;
        if (control_r[BIT_RUN] && countTick)
            count_nxt = 16'(count_r + 16'h0001);
        if (regWrite && regAddr == OFF_COUNT_LOW)
            count_nxt[7:0] = regWdata;
        if (regWrite && regAddr == OFF_COUNT_HIGH)
            count_nxt[15:8] = regWdata;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            count_r <= 16'h0000;
        else
            count_r <= count_nxt;
    end

    // ************************************************************
    // Interrupt
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            irqStatus_r <= 1'b0;
        else if (wrap)
            irqStatus_r <= 1'b1;
        else if (regWrite && regAddr == OFF_IRQ_CLEAR && regWdata[IRQ_OVF])
            irqStatus_r <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            irqEnable_r <= 1'b0;
        else if (regWrite && regAddr == OFF_IRQ_ENABLE)
            irqEnable_r <= regWdata[IRQ_OVF];
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= (irqStatus_r || wrap) && irqEnable_r;
    end

    // ************************************************************
    // Oscillator and pins
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            oscEnableOut <= 1'b0;
            pinC0Oe      <= 1'b0;
            pinC1Oe      <= 1'b0;
            pinC0Data    <= 1'b0;
            pinC1Data    <= 1'b0;
        end
        else
        begin
            oscEnableOut <= control_r[BIT_OSC_EN];
            pinC0Oe      <= !control_r[BIT_OSC_EN] && !portDir_r[0];
            pinC1Oe      <= !control_r[BIT_OSC_EN] && !portDir_r[1];
            pinC0Data    <= portC0Out;
            pinC1Data    <= portC1Out;
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            regRdata <= 8'h00;
        else if (regRead)
        begin
            unique case (regAddr)
                OFF_CONTROL:    regRdata <= control_r & CONTROL_MASK;
                OFF_COUNT_LOW:  regRdata <= count_r[7:0];
                OFF_COUNT_HIGH: regRdata <= count_r[15:8];
                OFF_IRQ_STATUS: regRdata <= {7'h00, irqStatus_r};
                OFF_IRQ_ENABLE: regRdata <= {7'h00, irqEnable_r};
                OFF_PORT_DIR:   regRdata <= portDir_r;
                OFF_PORT_READ:  regRdata <= control_r[BIT_OSC_EN] ? 8'h00
                                          : {6'h00, oscInPin, extClockPin};
                default:        regRdata <= 8'h00;
            endcase
        end
        else
            regRdata <= 8'h00;
    end
endmodule

// *** dv/stc_timer_assertions.sv ***
// Checker: port assertions of the timer control block
`timescale 1ns/1ps
module stc_timer_assertions
    import stc_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdata,
    input wire logic       extClockPin,
    input wire logic       oscInPin,
    input wire logic       portC0Out,
    input wire logic       portC1Out,
    input wire logic       oscEnableOut,
    input wire logic       pinC0Oe,
    input wire logic       pinC1Oe,
    input wire logic       pinC0Data,
    input wire logic       pinC1Data,
    input wire logic       irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence ctlWrite;
        regWrite && regAddr == OFF_CONTROL;
    endsequence
    sequence maskOff;
        regWrite && regAddr == OFF_IRQ_ENABLE && !regWdata[IRQ_OVF];
    endsequence
    osc_follow_a: assert property (
        ctlWrite ##1 !(regWrite && regAddr == OFF_CONTROL)
        |=> oscEnableOut == $past(regWdata[BIT_OSC_EN], 2)) else $error("osc enable lag");
    irq_mask_a: assert property (
        maskOff ##1 !(regWrite && regAddr == OFF_IRQ_ENABLE) |=> !irq) else $error("irq masked");
    oe_osc_a: assert property (
        oscEnableOut [*3] |-> !pinC0Oe && !pinC1Oe) else $error("pin driven with osc on");
    pin_read_a: assert property (
        oscEnableOut [*2] ##0 (regRead && regAddr == OFF_PORT_READ
        && !$past(regWrite && regAddr == OFF_CONTROL)) |=> regRdata == 8'h00)
        else $error("osc pins not zero");
    data_copy_a: assert property (
        pinC0Data == $past(portC0Out) && pinC1Data == $past(portC1Out)) else $error("pin data");
    rdata_idle_a: assert property (
        !$past(regRead) |-> regRdata == 8'h00) else $error("read data not idle");
    ctl_spare_a: assert property (
        regRead && regAddr == OFF_CONTROL |=> regRdata[7:6] == 2'h0) else $error("spare bits");
    unmapped_read_a: assert property (
        regRead && !(regAddr inside {[8'h0E:8'h10], [8'h20:8'h24]}) |=> regRdata == 8'h00)
        else $error("unmapped read");
endmodule
bind stc_timer stc_timer_assertions stc_timer_assertions_i (.clock(clock), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .extClockPin(extClockPin), .oscInPin(oscInPin),
    .portC0Out(portC0Out), .portC1Out(portC1Out), .oscEnableOut(oscEnableOut),
    .pinC0Oe(pinC0Oe), .pinC1Oe(pinC1Oe), .pinC0Data(pinC0Data), .pinC1Data(pinC1Data),
    .irq(irq));

// *** dv/stc_ext_source.sv ***
// Model: external count clock and timer crystal on the oscillator pins
`timescale 1ns/1ps
module stc_ext_source
(
    input  wire logic clock,
    input  wire logic oscEnable,
    output      logic extClock,
    output      logic oscIn
);
    logic [1:0] phase = 2'h0;
    initial extClock = 1'b0;
    initial oscIn = 1'b0;
    // Crystal swings only while its inverter is powered
    always @(posedge clock)
    begin
        phase <= phase + 2'h1;
        oscIn <= oscEnable & phase[1];
    end
    // Burst of rising edges, pin low between bursts
    task automatic pulses(input int n, input int half);
        repeat (n)
        begin
            repeat (half) @(posedge clock);
            extClock <= 1'b1;
            repeat (half) @(posedge clock);
            extClock <= 1'b0;
        end
    endtask
endmodule

// *** dv/tb_top.sv ***
// Testbench: register, counting, overflow and pin scenarios of the timer control
`timescale 1ns/1ps
module tb_top
    import stc_pkg::*;
;
    logic       clock = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, rdPend = 1'b0;
    logic       portC0Out = 1'b0, portC1Out = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
    logic       extClockPin, oscInPin, oscEnableOut, pinC0Oe, pinC1Oe, pinC0Data, pinC1Data, irq;
    logic [31:0] seed = 32'h279D;
    logic [7:0] expQ[$];
    int         nFail = 0, compares = 0;
    always #10 clock = ~clock;
    stc_timer stc_timer_i (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .extClockPin(extClockPin), .oscInPin(oscInPin), .portC0Out(portC0Out),
        .portC1Out(portC1Out), .oscEnableOut(oscEnableOut), .pinC0Oe(pinC0Oe),
        .pinC1Oe(pinC1Oe), .pinC0Data(pinC0Data), .pinC1Data(pinC1Data), .irq(irq));
    stc_ext_source stc_ext_source_i (.clock(clock), .oscEnable(oscEnableOut),
        .extClock(extClockPin), .oscIn(oscInPin));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e)
        begin
            nFail++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= w;
        regRead <= !w;
        regAddr <= a;
        regWdata <= d;
        @(posedge clock);
        regWrite <= 1'b0;
        regRead <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        op(1'b0, a, 8'h00);
    endtask
    task automatic outs(input string what, input logic [7:0] e);
        repeat (2) @(posedge clock);
        #1;
        check(what, e, {5'h00, oscEnableOut, pinC1Oe & pinC0Oe, irq});
    endtask
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", compares, nFail);
        if (nFail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Random port data; read results checked one cycle after the strobe
    always @(posedge clock)
    begin
        if (rst_n)
        begin
            seed <= xs(seed);
            portC0Out <= seed[0];
            portC1Out <= seed[1];
        end
        rdPend <= regRead;
        if (rdPend)
            check("read data", expQ.pop_front(), regRdata);
    end
    initial
    begin
        #400000;
        nFail++;
        summarize();
    end
    initial
    begin
        logic [7:0] r;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rd(OFF_CONTROL, CONTROL_RESET);
        rd(OFF_PORT_DIR, PORT_DIR_RESET);
        rd(8'h30, 8'h00);
        for (int m = 0; m < 8; m++)
        begin
            op(1'b1, OFF_CONTROL, 8'h00);
            op(1'b1, OFF_COUNT_LOW, 8'h00);
            op(1'b1, OFF_CONTROL, 8'((m % 4) << 4 | (m / 4) << 2 | 3));
            stc_ext_source_i.pulses(16, 3);
            repeat (6) @(posedge clock);
            op(1'b1, OFF_CONTROL, 8'h02);
            rd(OFF_COUNT_LOW, 8'(16 >> (m % 4)));
        end
        op(1'b1, OFF_COUNT_LOW, 8'h00);
        op(1'b1, OFF_CONTROL, 8'h05);
        repeat (398) @(posedge clock);
        op(1'b1, OFF_CONTROL, 8'h00);
        rd(OFF_COUNT_LOW, 8'h64);
        r = seed[7:0];
        op(1'b1, OFF_COUNT_LOW, r);
        op(1'b1, OFF_CONTROL, 8'h06);
        stc_ext_source_i.pulses(5, 3);
        rd(OFF_COUNT_LOW, r);
        op(1'b1, OFF_COUNT_HIGH, 8'hFF);
        op(1'b1, OFF_COUNT_LOW, 8'hFE);
        op(1'b1, OFF_IRQ_ENABLE, 8'h01);
        op(1'b1, OFF_CONTROL, 8'h07);
        stc_ext_source_i.pulses(2, 3);
        op(1'b1, OFF_CONTROL, 8'h00);
        rd(OFF_COUNT_HIGH, 8'h00);
        rd(OFF_COUNT_LOW, 8'h00);
        rd(OFF_IRQ_STATUS, 8'h01);
        outs("irq set", 8'h01);
        op(1'b1, OFF_IRQ_ENABLE, 8'h00);
        outs("irq masked", 8'h00);
        op(1'b1, OFF_IRQ_ENABLE, 8'h01);
        outs("irq unmasked", 8'h01);
        op(1'b1, OFF_IRQ_CLEAR, 8'h01);
        outs("irq cleared", 8'h00);
        rd(OFF_IRQ_STATUS, 8'h00);
        op(1'b1, OFF_PORT_DIR, 8'h00);
        outs("pins driven", 8'h02);
        op(1'b1, OFF_CONTROL, 8'hC8);
        outs("osc on", 8'h04);
        rd(OFF_CONTROL, 8'h08);
        repeat (3) rd(OFF_PORT_READ, 8'h00);
        op(1'b1, OFF_CONTROL, 8'h00);
        outs("osc off", 8'h02);
        repeat (3) @(posedge clock);
        summarize();
    end
endmodule
